// >>> hw/trail_trace_receiver.sv
// Functional notes
// - Alignment enabled: find multiframe start, store bytes in aligned order.
// - Alignment disabled: store bytes starting from whichever byte arrives first.
// - Compare enable gates received versus expected identifier comparison.
// - Alignment disabled suppresses comparison regardless of compare enable.
// - Invert control inverts every incoming bit before processing.
// - Reorder control puts first bit in stored LSB instead of MSB.
// - Expected pointer in bits 11..8 selects next expected byte accessed.
// - Expected pointer increments per expected access, wrapping F to 0.
// - Received pointer in bits 3..0 selects next received byte read.
// - Received pointer increments per received port read, wrapping F to 0.
// - Mismatch flag is one while received differs from expected identifier.
// - Unstable flag set after eight identifiers matching neither stored nor previous.
// - Idle flag set after five consecutive all-zero identifiers, else cleared.
// - Latched bits set on rising live flags; change bit on identifier update.
// - Interrupt needs latched bit, its enable, and port interrupt enable.
// - Reading received data port returns pointed byte and advances pointer.
`timescale 1ns/1ps
module trail_trace_receiver
  import trail_trace_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tt_bit,
  input wire logic tt_valid,
  input wire logic tt_byte_start,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  input wire logic port_irq_enable,
  output logic irq
);
  logic [3:0] control_q;
  logic [3:0] exp_ptr_q;
  logic [3:0] rx_ptr_q;
  logic [3:0] latched_q;
  logic [3:0] irq_en_q;
  logic mismatch_flag_q;
  logic unstable_flag_q;
  logic idle_flag_q;
  logic [ID_BYTES-1:0][7:0] cur_q;
  logic [ID_BYTES-1:0][7:0] prev_q;
  logic [ID_BYTES-1:0][7:0] rx_id_q;
  logic [ID_BYTES-1:0][7:0] exp_id_q;
  logic [3:0] index_q;
  logic frame_done_q;
  logic [3:0] unstable_cnt_q;
  logic [3:0] idle_cnt_q;
  logic updated_q;
  logic prev_mismatch_q;
  logic prev_unstable_q;
  logic prev_idle_q;
  align_state_t state_q;

  logic align_disable;
  logic compare_enable;
  logic compare_active;
  logic asm_valid;
  logic asm_ready;
  logic [8:0] asm_data;
  logic byte_valid;
  logic byte_ready;
  logic [8:0] byte_data;
  logic take;
  logic mas_bit;
  logic store_en;
  logic [3:0] store_idx;
  logic wr_ctl;
  logic wr_ptr;
  logic wr_lat;
  logic wr_ie;
  logic exp_access;
  logic rx_access;
  logic cand_zero;
  logic cand_is_prev;
  logic cand_is_rx;

  assign align_disable = control_q[BIT_ALIGN_DISABLE];
  assign compare_enable = control_q[BIT_COMPARE_ENABLE];
  assign compare_active = compare_enable && !align_disable;

  trace_byte_assembler u_assembler (
    .clock(clock),
    .rst(rst),
    .tt_bit(tt_bit),
    .tt_valid(tt_valid),
    .tt_byte_start(tt_byte_start),
    .invert(control_q[BIT_INVERT]),
    .reorder(control_q[BIT_REORDER]),
    .out_valid(asm_valid),
    .out_data(asm_data),
    .out_ready(asm_ready)
  );

  trace_byte_buffer #(
    .WIDTH(9),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .clock(clock),
    .rst(rst),
    .in_valid(asm_valid),
    .in_ready(asm_ready),
    .in_data(asm_data),
    .out_valid(byte_valid),
    .out_ready(byte_ready),
    .out_data(byte_data)
  );

  // Host decode
  assign wr_ctl = host_wr && host_addr == OFS_RX_CONTROL;
  assign wr_ptr = host_wr && host_addr == OFS_POINTERS;
  assign wr_lat = host_wr && host_addr == OFS_LATCHED_STATUS;
  assign wr_ie = host_wr && host_addr == OFS_IRQ_ENABLE;
  assign exp_access = (host_wr || host_rd) && host_addr == OFS_EXP_ID_PORT;
  assign rx_access = host_rd && host_addr == OFS_RX_ID_PORT;

  // Store stalls while evaluating a finished identifier
  assign byte_ready = !frame_done_q;
  assign take = byte_valid && byte_ready;
  assign mas_bit = byte_data[8];

  // byte with alignment bit set is byte 0
  always_comb begin
    store_en = 1'b0;
    store_idx = index_q;
    if (take) begin
      if (align_disable) begin
        store_en = 1'b1;
      end else if (state_q == ALIGN_SEARCH) begin
        store_en = mas_bit;
        store_idx = 4'h0;
      end else begin
        store_en = (index_q == 4'h0) == mas_bit;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ALIGN_SEARCH;
      index_q <= 4'h0;
    end else if (wr_ctl) begin
      state_q <= ALIGN_SEARCH;
      index_q <= 4'h0;
    end else if (take) begin
      case (state_q)
        ALIGN_SEARCH: begin
          if (align_disable) begin
            state_q <= ALIGN_LOCKED;
            index_q <= 4'h1;
          end else if (mas_bit) begin
            state_q <= ALIGN_LOCKED;
            index_q <= 4'h1;
          end
        end
        ALIGN_LOCKED: begin
          if (store_en) begin
            index_q <= index_q + 4'h1;
          end else begin
            state_q <= ALIGN_SEARCH;
            index_q <= 4'h0;
          end
        end
        default: begin
          state_q <= ALIGN_SEARCH;
          index_q <= 4'h0;
        end
      endcase
    end
  end

  // Incoming bytes of the identifier being received
  always_ff @(posedge clock) begin
    if (rst) begin
      cur_q <= '0;
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= store_en && store_idx == 4'(ID_BYTES - 1);
      if (store_en) begin
        cur_q[store_idx] <= byte_data[7:0];
      end
    end
  end

  assign cand_zero = cur_q == '0;
  assign cand_is_prev = cur_q == prev_q;
  assign cand_is_rx = cur_q == rx_id_q;

  // Accept an identifier seen twice in a row
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_q <= '0;
      rx_id_q <= '0;
      updated_q <= 1'b0;
    end else begin
      updated_q <= 1'b0;
      if (frame_done_q) begin
        prev_q <= cur_q;
        if (cand_is_prev && !cand_is_rx) begin
          rx_id_q <= cur_q;
          updated_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      unstable_cnt_q <= 4'h0;
      unstable_flag_q <= 1'b0;
    end else if (frame_done_q) begin
      if (cand_is_prev || cand_is_rx) begin
        unstable_cnt_q <= 4'h0;
        unstable_flag_q <= 1'b0;
      end else if (unstable_cnt_q != 4'(UNSTABLE_COUNT)) begin
        unstable_cnt_q <= unstable_cnt_q + 4'h1;
        unstable_flag_q <= unstable_cnt_q == 4'(UNSTABLE_COUNT - 1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      idle_cnt_q <= 4'h0;
      idle_flag_q <= 1'b0;
    end else if (frame_done_q) begin
      if (!cand_zero) begin
        idle_cnt_q <= 4'h0;
        idle_flag_q <= 1'b0;
      end else if (idle_cnt_q != 4'(IDLE_COUNT)) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
        idle_flag_q <= idle_cnt_q == 4'(IDLE_COUNT - 1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mismatch_flag_q <= 1'b0;
    end else begin
      mismatch_flag_q <= compare_active && (rx_id_q != exp_id_q);
    end
  end

  // latch rising edges, set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      latched_q <= 4'h0;
      prev_mismatch_q <= 1'b0;
      prev_unstable_q <= 1'b0;
      prev_idle_q <= 1'b0;
    end else begin
      prev_mismatch_q <= mismatch_flag_q;
      prev_unstable_q <= unstable_flag_q;
      prev_idle_q <= idle_flag_q;
      latched_q <= (latched_q & ~(wr_lat ? host_wdata[3:0] : 4'h0))
        | {updated_q, mismatch_flag_q & ~prev_mismatch_q,
           unstable_flag_q & ~prev_unstable_q, idle_flag_q & ~prev_idle_q};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= port_irq_enable && |(latched_q & irq_en_q);
    end
  end

  // Control and enable registers
  always_ff @(posedge clock) begin
    if (rst) begin
      control_q <= CONTROL_RESET;
      irq_en_q <= 4'h0;
    end else begin
      if (wr_ctl) begin
        control_q <= host_wdata[3:0];
      end
      if (wr_ie) begin
        irq_en_q <= host_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      exp_ptr_q <= PTR_RESET;
      rx_ptr_q <= PTR_RESET;
    end else if (wr_ptr) begin
      exp_ptr_q <= host_wdata[EXP_PTR_LSB +: 4];
      rx_ptr_q <= host_wdata[RX_PTR_LSB +: 4];
    end else begin
      // expected pointer wraps F to 0
      if (exp_access) begin
        exp_ptr_q <= exp_ptr_q + 4'h1;
      end
      if (rx_access) begin
        rx_ptr_q <= rx_ptr_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      exp_id_q <= '0;
    end else if (host_wr && host_addr == OFS_EXP_ID_PORT) begin
      exp_id_q[exp_ptr_q] <= host_wdata[7:0];
    end
  end

  // Read data, one cycle after the strobe; unused offsets read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      host_rdata <= 16'h0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        case (host_addr)
          OFS_RX_CONTROL: host_rdata <= {12'h000, control_q};
          OFS_POINTERS: host_rdata <= {4'h0, exp_ptr_q, 4'h0, rx_ptr_q};
          OFS_LIVE_STATUS: host_rdata <= {13'h0000, mismatch_flag_q, unstable_flag_q,
                                          idle_flag_q};
          OFS_LATCHED_STATUS: host_rdata <= {12'h000, latched_q};
          OFS_IRQ_ENABLE: host_rdata <= {12'h000, irq_en_q};
          OFS_RX_ID_PORT: host_rdata <= {8'h00, rx_id_q[rx_ptr_q]};
          OFS_EXP_ID_PORT: host_rdata <= {8'h00, exp_id_q[exp_ptr_q]};
          default: host_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // trail_trace_receiver

// >>> pkg/trail_trace_pkg.sv
package trail_trace_pkg;
  // Register offsets on the host port
  localparam logic [7:0] OFS_RX_CONTROL = 8'hF0;
  localparam logic [7:0] OFS_POINTERS = 8'hF2;
  localparam logic [7:0] OFS_LIVE_STATUS = 8'hF4;
  localparam logic [7:0] OFS_LATCHED_STATUS = 8'hF6;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'hF8;
  localparam logic [7:0] OFS_RX_ID_PORT = 8'hFC;
  localparam logic [7:0] OFS_EXP_ID_PORT = 8'hFE;

  // Control bit positions
  localparam int BIT_ALIGN_DISABLE = 3;
  localparam int BIT_COMPARE_ENABLE = 2;
  localparam int BIT_INVERT = 1;
  localparam int BIT_REORDER = 0;

  // Pointer register fields
  localparam int EXP_PTR_LSB = 8;
  localparam int RX_PTR_LSB = 0;

  // Status bit positions (live: 2..0, latched/enable: 3..0)
  localparam int BIT_CHANGE = 3;
  localparam int BIT_MISMATCH = 2;
  localparam int BIT_UNSTABLE = 1;
  localparam int BIT_IDLE = 0;

  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Identifier length and persistence counts
  localparam int ID_BYTES = 16;
  localparam int UNSTABLE_COUNT = 8;
  localparam int IDLE_COUNT = 5;
  localparam int BITS_PER_BYTE = 8;

  typedef enum logic [1:0] {
    ALIGN_SEARCH = 2'b01,
    ALIGN_LOCKED = 2'b10
  } align_state_t;
endpackage

// >>> hw/trace_byte_assembler.sv
`timescale 1ns/1ps
module trace_byte_assembler
  import trail_trace_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic tt_bit,
  input wire logic tt_valid,
  input wire logic tt_byte_start,
  input wire logic invert,
  input wire logic reorder,
  output logic out_valid,
  output logic [8:0] out_data,
  input wire logic out_ready
);
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [2:0] count_q;
  logic first_q;
  logic bit_in;
  logic [2:0] count_now;

  assign bit_in = tt_bit ^ invert;
  assign count_now = tt_byte_start ? 3'h0 : count_q;

  // first bit to MSB or LSB
  always_comb begin
    if (reorder) begin
      shift_d = {bit_in, shift_q[7:1]};
    end else begin
      shift_d = {shift_q[6:0], bit_in};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shift_q <= 8'h00;
      count_q <= 3'h0;
      first_q <= 1'b0;
    end else if (tt_valid) begin
      shift_q <= shift_d;
      count_q <= count_now + 3'h1;
      if (count_now == 3'h0) begin
        first_q <= bit_in;
      end
    end
  end

  // Byte plus its first (alignment) bit; held until taken
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= 9'h000;
    end else if (tt_valid && count_now == 3'h7 && (!out_valid || out_ready)) begin
      out_valid <= 1'b1;
      out_data <= {(count_now == 3'h0) ? bit_in : first_q, shift_d};
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // trace_byte_assembler

// >>> hw/trace_byte_buffer.sv
`timescale 1ns/1ps
module trace_byte_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] used_q;
  logic push;
  logic pop;

  assign in_ready = used_q != (AW+1)'(DEPTH);
  assign out_valid = used_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      used_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      used_q <= used_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // trace_byte_buffer

// >>> tb/trail_trace_receiver_properties.sv
`timescale 1ns/1ps
module trail_trace_receiver_properties
  import trail_trace_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic port_irq_enable,
  input wire logic irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [3:0] ctrl_q;
  logic [3:0] ien_q;
  // Shadow copies of control and interrupt enables
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= CONTROL_RESET;
      ien_q <= 4'h0;
    end else if (host_wr) begin
      if (host_addr == OFS_RX_CONTROL) ctrl_q <= host_wdata[3:0];
      if (host_addr == OFS_IRQ_ENABLE) ien_q <= host_wdata[3:0];
    end
  end
  sequence wr_at(logic [7:0] a);
    host_wr && host_addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    host_rd && host_addr == a;
  endsequence
  a_read_answered: assert property (host_rd |=> host_rvalid)
    else $error("read not answered");
  a_answer_caused: assert property (host_rvalid |-> $past(host_rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved");
  a_control_readback: assert property (
    wr_at(OFS_RX_CONTROL) ##1 rd_at(OFS_RX_CONTROL)
    |=> host_rdata[3:0] == $past(host_wdata[3:0], 2))
    else $error("control readback wrong");
  a_rx_ptr_step: assert property (
    wr_at(OFS_POINTERS) ##1 rd_at(OFS_RX_ID_PORT) ##1 rd_at(OFS_POINTERS)
    |=> host_rdata[3:0] == $past(host_wdata[3:0], 3) + 4'h1)
    else $error("received pointer did not step");
  a_exp_ptr_step: assert property (
    wr_at(OFS_POINTERS) ##1 rd_at(OFS_EXP_ID_PORT) ##1 rd_at(OFS_POINTERS)
    |=> host_rdata[11:8] == $past(host_wdata[11:8], 3) + 4'h1)
    else $error("expected pointer did not step");
  a_irq_cause: assert property (
    irq |-> $past(port_irq_enable) && $past(ien_q) != 4'h0)
    else $error("interrupt without enables");
  a_irq_port_off: assert property (!port_irq_enable |=> !irq)
    else $error("interrupt with port disabled");
  a_mismatch_gated: assert property (
    host_rd && host_addr == OFS_LIVE_STATUS && !$past(host_wr) && !$past(host_wr, 2)
    && !(ctrl_q[BIT_COMPARE_ENABLE] && !ctrl_q[BIT_ALIGN_DISABLE])
    |=> !host_rdata[BIT_MISMATCH])
    else $error("mismatch while comparison off");
endmodule // trail_trace_receiver_properties

bind trail_trace_receiver trail_trace_receiver_properties u_props (
  .clock(clock), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .port_irq_enable(port_irq_enable), .irq(irq)
);

// >>> tb/trace_overhead_source.sv
`timescale 1ns/1ps
module trace_overhead_source (
  input wire logic clock,
  output logic tt_bit,
  output logic tt_valid,
  output logic tt_byte_start
);
  logic busy = 1'b0;
  initial begin
    tt_bit = 1'b0;
    tt_valid = 1'b0;
    tt_byte_start = 1'b0;
  end
  // Outside frames the line wanders, never holding the last bit
  always @(negedge clock) begin
    if (!busy) tt_bit <= ~tt_bit;
  end
  // Sends n bytes from byte first on, first bit first; vary alters byte 15 per frame
  task automatic send(input logic [7:0] b [16], input int first, input int n,
                      input int gap, input logic inv, input logic vary);
    logic [7:0] v;
    busy = 1'b1;
    for (int k = 0; k < n; k++) begin
      v = b[(first + k) % 16];
      if (vary && (first + k) % 16 == 15) v = v ^ 8'(k / 16 + 1);
      for (int i = 7; i >= 0; i--) begin
        @(negedge clock);
        tt_bit = v[i] ^ inv;
        tt_valid = 1'b1;
        tt_byte_start = (i == 7);
        @(negedge clock);
        tt_valid = 1'b0;
        tt_byte_start = 1'b0;
        tt_bit = ~tt_bit;
        repeat (gap) @(negedge clock);
      end
      repeat (3) @(negedge clock);
    end
    busy = 1'b0;
  endtask
endmodule // trace_overhead_source

// >>> tb/trail_trace_receiver_tb.sv
`timescale 1ns/1ps
module trail_trace_receiver_tb;
  import trail_trace_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic tt_bit;
  logic tt_valid;
  logic tt_byte_start;
  logic [7:0] host_addr = 8'h00;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [15:0] host_wdata = 16'h0000;
  logic [15:0] host_rdata;
  logic host_rvalid;
  logic port_irq_enable = 1'b0;
  logic irq;
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] id [16];
  logic [7:0] zid [16];
  logic [7:0] e [16];
  logic [7:0] regs [8] = '{8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC, 8'hFE};
  logic [15:0] ctl [4] = '{16'h0000, 16'h0008, 16'h000C, 16'h0004};

  always #2.5 clock = ~clock;

  trail_trace_receiver DUT (.clock(clock), .rst(rst), .tt_bit(tt_bit),
    .tt_valid(tt_valid), .tt_byte_start(tt_byte_start), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .port_irq_enable(port_irq_enable), .irq(irq));
  trace_overhead_source src (.clock(clock), .tt_bit(tt_bit), .tt_valid(tt_valid),
    .tt_byte_start(tt_byte_start));

  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [15:0] d);
    @(negedge clock);
    host_wr = w;
    host_rd = r;
    host_addr = a;
    host_wdata = d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    op(1'b0, 1'b1, a, 16'h0000);
    idle(1);
    chk(host_rdata, exp);
    chk({15'h0000, host_rvalid}, 16'h0001);
  endtask
  task automatic step(input logic [7:0] port, input logic [15:0] exp);
    wr(OFS_POINTERS, 16'h0F0F);
    op(1'b0, 1'b1, port, 16'h0000);
    rd(OFS_POINTERS, exp);
  endtask
  task automatic cmp_rx();
    wr(OFS_POINTERS, 16'h0000);
    for (int k = 0; k < 16; k++) rd(OFS_RX_ID_PORT, {8'h00, e[k]});
  endtask
  task automatic recv(input logic [15:0] c, input logic [7:0] b [16], input int first,
                      input int n, input int gap, input logic vary);
    wr(OFS_RX_CONTROL, c);
    idle(1);
    src.send(b, first, n, gap, 1'b0, vary);
    idle(8);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #150us;
    miscompares++;
    end_of_test();
  end

  initial begin
    for (int i = 0; i < 16; i++) begin
      id[i] = 8'(i * 19 + 33) & 8'h7F;
      zid[i] = 8'h00;
    end
    id[0][7] = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(regs[i], 16'h0000);
    wr(8'hFA, 16'hFFFF);
    wr(OFS_LIVE_STATUS, 16'hFFFF);
    rd(8'hFA, 16'h0000);
    rd(OFS_LIVE_STATUS, 16'h0000);
    wr(OFS_RX_CONTROL, 16'h000F);
    rd(OFS_RX_CONTROL, 16'h000F);
    wr(OFS_POINTERS, 16'h0000);
    for (int k = 0; k < 16; k++) wr(OFS_EXP_ID_PORT, {8'h00, id[k]});
    rd(OFS_POINTERS, 16'h0000);
    step(OFS_RX_ID_PORT, 16'h0F00);
    step(OFS_EXP_ID_PORT, 16'h000F);
    wr(OFS_POINTERS, 16'h0E00);
    rd(OFS_EXP_ID_PORT, {8'h00, id[14]});
    rd(OFS_EXP_ID_PORT, {8'h00, id[15]});
    rd(OFS_EXP_ID_PORT, {8'h00, id[0]});
    recv(16'h0004, id, 5, 48, 0, 1'b0);
    e = id;
    cmp_rx();
    rd(OFS_LIVE_STATUS, 16'h0000);
    wr(OFS_POINTERS, 16'h0300);
    wr(OFS_EXP_ID_PORT, 16'h0055);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_RX_CONTROL, ctl[i]);
      idle(3);
      rd(OFS_LIVE_STATUS, (i == 3) ? 16'h0004 : 16'h0000);
    end
    rd(OFS_LATCHED_STATUS, 16'h000C);
    wr(OFS_IRQ_ENABLE, 16'h0001);
    port_irq_enable = 1'b1;
    idle(3);
    chk({15'h0000, irq}, 16'h0000);
    wr(OFS_IRQ_ENABLE, 16'h0008);
    idle(3);
    chk({15'h0000, irq}, 16'h0001);
    port_irq_enable = 1'b0;
    idle(3);
    chk({15'h0000, irq}, 16'h0000);
    port_irq_enable = 1'b1;
    wr(OFS_LATCHED_STATUS, 16'h000C);
    idle(3);
    chk({15'h0000, irq}, 16'h0000);
    rd(OFS_LATCHED_STATUS, 16'h0000);
    wr(OFS_RX_CONTROL, 16'h000A);
    idle(1);
    src.send(id, 5, 32, 1, 1'b0, 1'b0);
    idle(8);
    for (int k = 0; k < 16; k++) e[k] = ~id[(k + 5) % 16];
    cmp_rx();
    recv(16'h0001, id, 0, 48, 0, 1'b0);
    for (int k = 0; k < 16; k++) e[k] = {<<{id[k]}};
    cmp_rx();
    wr(OFS_POINTERS, 16'h0007);
    rd(OFS_RX_ID_PORT, {8'h00, e[7]});
    recv(16'h0008, zid, 0, 64, 0, 1'b0);
    rd(OFS_LIVE_STATUS, 16'h0000);
    src.send(zid, 0, 16, 0, 1'b0, 1'b0);
    idle(8);
    rd(OFS_LIVE_STATUS, 16'h0001);
    src.send(id, 0, 112, 0, 1'b0, 1'b1);
    idle(8);
    rd(OFS_LIVE_STATUS, 16'h0000);
    src.send(id, 0, 16, 0, 1'b0, 1'b1);
    idle(8);
    rd(OFS_LIVE_STATUS, 16'h0002);
    rd(OFS_LATCHED_STATUS, 16'h000B);
    end_of_test();
  end
endmodule // trail_trace_receiver_tb
